// File: dv/fsp_flash_self_program_tb.sv
`timescale 1ns/100ps
module fsp_flash_self_program_tb
	import fsp_pkg::*;
;
	// ****************************************
	// Stimulus, design and scoreboard state
	// ****************************************
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic warm_rst_n = 1'h1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic [23:0] flash_rdata = 24'h0;
	logic [5:0] buf_idx = 6'h0;
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic cmd_go_ff, cpu_stall_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [23:0] flash_raddr_ff, buf_data_ff, tgt;
	logic [23:0] bufm [64];
	fsp_cmd_s cmd_ff;
	fsp_op_e k;
	logic [15:0] c;
	logic [33:0] rq [$];
	logic [1:0] bq [$];
	logic [26:0] cq [$];
	int errors = 0;
	int checks = 0;
	int seed = 88030;

	always #5 aclk = ~aclk;

	// Short operation counts keep the run brief; row, page and word get their own, and bulk and both segment erases share BULK_RC.
	fsp_flash_self_program #(.ROW_RC(3), .PAGE_RC(4), .WORD_RC(2),
		.BULK_RC(5)) dut (
		.aclk(aclk), .aresetn(aresetn), .warm_rst_n(warm_rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready_ff(awready_ff),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready_ff(wready_ff), .bresp_ff(bresp_ff), .bvalid_ff(bvalid_ff),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready_ff(arready_ff), .rdata_ff(rdata_ff), .rresp_ff(rresp_ff),
		.rvalid_ff(rvalid_ff), .rready(rready), .cmd_ff(cmd_ff),
		.cmd_go_ff(cmd_go_ff), .flash_raddr_ff(flash_raddr_ff),
		.flash_rdata(flash_rdata), .buf_idx(buf_idx),
		.buf_data_ff(buf_data_ff), .cpu_stall_ff(cpu_stall_ff));

	// ****************************************
	// Compare, verdict and bus tasks
	// ****************************************
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OK);
		int n;
		@(posedge aclk);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			if (awready_ff) awvalid <= 1'h0;
			if (wready_ff) wvalid <= 1'h0;
			n++;
		end while (!bvalid_ff && n < 500);
		bready <= 1'h0;
		if (n >= 500) begin
			errors++;
			tally_and_finish;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OK);
		int n;
		@(posedge aclk);
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			if (arready_ff) arvalid <= 1'h0;
			n++;
		end while (!rvalid_ff && n < 500);
		rready <= 1'h0;
		if (n >= 500) begin
			errors++;
			tally_and_finish;
		end
	endtask

	task automatic go(input logic [15:0] v, input logic [7:0] k2 = KEY2);
		wr(A_CTRL, {16'h0, v});
		wr(A_KEY, {24'h0, KEY1});
		wr(A_KEY, {24'h0, k2});
		wr(A_CTRL, {16'h0, v | 16'h8000});
		repeat (2) @(posedge aclk);
	endtask

	task automatic idle;
		int n;
		n = 0;
		while (cpu_stall_ff && n < 400) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 400) begin
			errors++;
			tally_and_finish;
		end
	endtask

	function automatic fsp_op_e kind_of(input logic [4:0] eo);
		case (eo)
			{1'h1, OP_BULK}: return FSP_BULK;
			{1'h1, OP_PAGE}: return FSP_PAGE;
			{1'h1, OP_GSEG}: return FSP_GSEG;
			{1'h1, OP_SSEG}: return FSP_SSEG;
			{1'h0, OP_ROW}: return FSP_ROW;
			{1'h0, OP_WORD}: return FSP_WORD;
			default: return FSP_NONE;
		endcase
	endfunction

	function automatic logic [23:0] addr_of(input fsp_op_e kk);
		case (kk)
			FSP_PAGE: return {tgt[23:10], 10'h0};
			FSP_ROW: return {tgt[23:7], 7'h0};
			FSP_WORD: return {tgt[23:1], 1'h0};
			default: return 24'h0;
		endcase
	endfunction

	// ****************************************
	// Output watcher
	// ****************************************
	// An operation launch with nothing noted pops an all-X entry and so fails.
	always @(posedge aclk) begin
		if (rvalid_ff && rready) cmp({rresp_ff, rdata_ff}, rq.pop_front());
		if (bvalid_ff && bready) cmp(bresp_ff, bq.pop_front());
		if (cmd_go_ff) cmp({cpu_stall_ff, cmd_ff}, {1'h1, cq.pop_front()});
	end

	initial begin
		#500000;
		errors++;
		tally_and_finish;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		rd(A_CTRL, 32'h0);
		rd(8'h40, 32'h0, RESP_ERR);
		wr(8'h40, 32'h1, RESP_ERR);
		wr(A_CTRL, 32'hdfff);
		rd(A_CTRL, 32'h604f);
		wr(A_CTRL, 32'h0);
		wr(A_PAGE, 32'h5a);
		wr(A_EA, 32'hc3e6);
		flash_rdata <= 24'($random(seed));
		repeat (2) @(posedge aclk);
		cmp(flash_raddr_ff, 24'h5ac3e6);
		rd(A_TLOW, {16'h0, flash_rdata[15:0]});
		rd(A_THIGH, {24'h0, flash_rdata[23:16]});
		wr(A_PAGE, 32'h01);
		for (int i = 0; i < 64; i++) begin
			bufm[i] = 24'($random(seed));
			wr(A_EA, 32'h180 + 32'(2 * i));
			wr(A_TLOW, {16'h0, bufm[i][15:0]});
			wr(A_THIGH, {24'h0, bufm[i][23:16]});
		end
		tgt = 24'h0101fe;
		rd(A_STAT, {25'h0, FILL_FULL});
		for (int i = 0; i < 64; i++) begin
			@(posedge aclk);
			buf_idx <= 6'(i);
			@(posedge aclk);
			#1 cmp(buf_data_ff, bufm[i]);
		end
		for (int i = 0; i < 32; i++) begin
			c = {2'h1, 7'h0, i[4], 2'h0, i[3:0]};
			k = kind_of({i[4], i[3:0]});
			if (k != FSP_NONE) cq.push_back({k, addr_of(k)});
			go(c);
			idle;
			rd(A_CTRL, {16'h0, c});
		end
		rd(A_STAT, 32'h0);
		go(16'h4001, KEY1);
		rd(A_CTRL, 32'h6001);
		go(16'h0001);
		rd(A_CTRL, 32'h2001);
		cq.push_back({FSP_ROW, tgt[23:7], 7'h0});
		go(16'h4001);
		warm_rst_n <= 1'h0;
		repeat (2) @(posedge aclk);
		warm_rst_n <= 1'h1;
		idle;
		rd(A_CTRL, 32'h6001);
		aresetn <= 1'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		rd(A_CTRL, 32'h0);
		tally_and_finish;
	end
endmodule

// File: hw/fsp_flash_self_program.sv
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module fsp_flash_self_program
	import fsp_pkg::*;
#(
	parameter int ROW_RC = ROW_RC_CYCLES,
	parameter int PAGE_RC = ROW_RC_CYCLES,
	parameter int WORD_RC = ROW_RC_CYCLES,
	parameter int BULK_RC = ROW_RC_CYCLES
) (
	// Clock and resets.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic warm_rst_n,
	// AXI4-Lite slave.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready_ff,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready_ff,
	output logic [1:0] bresp_ff,
	output logic bvalid_ff,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready_ff,
	output logic [31:0] rdata_ff,
	output logic [1:0] rresp_ff,
	output logic rvalid_ff,
	input wire logic rready,
	// Flash array side.
	output fsp_cmd_s cmd_ff,
	output logic cmd_go_ff,
	output logic [23:0] flash_raddr_ff,
	input wire logic [23:0] flash_rdata,
	input wire logic [5:0] buf_idx,
	output logic [23:0] buf_data_ff,
	// Processor stall.
	output logic cpu_stall_ff
);
	// ****************************************
	// Bus write path
	// ****************************************
	logic aw_hold_ff, w_hold_ff, wcnt_ff, wr_tbl, wr_fire, wr_map;
	logic [7:0] waddr_ff, rd_addr_ff;
	logic [31:0] wdat_ff;
	logic [3:0] wstb_ff;
	assign wr_tbl = waddr_ff == A_TLOW || waddr_ff == A_THIGH;
	// A table write answers one cycle later than other writes.
	assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff &&
		(!wr_tbl || wcnt_ff);
	assign wr_map = waddr_ff == A_CTRL || waddr_ff == A_KEY ||
		waddr_ff == A_PAGE || waddr_ff == A_EA || wr_tbl ||
		waddr_ff == A_STAT;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			awready_ff <= 1'b0;
			waddr_ff <= 8'h00;
		end else if (awvalid && awready_ff) begin
			aw_hold_ff <= 1'b1;
			awready_ff <= 1'b0;
			waddr_ff <= awaddr;
		end else if ((bvalid_ff && bready) || !aw_hold_ff) begin
			aw_hold_ff <= 1'b0;
			awready_ff <= 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_ff <= 1'b0;
			wready_ff <= 1'b0;
			wdat_ff <= 32'h0000_0000;
			wstb_ff <= 4'h0;
		end else if (wvalid && wready_ff) begin
			w_hold_ff <= 1'b1;
			wready_ff <= 1'b0;
			wdat_ff <= wdata;
			wstb_ff <= wstrb;
		end else if ((bvalid_ff && bready) || !w_hold_ff) begin
			w_hold_ff <= 1'b0;
			wready_ff <= 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wcnt_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OK;
		end else if (wr_fire) begin
			wcnt_ff <= 1'b0;
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_map ? RESP_OK : RESP_ERR;
		end else begin
			wcnt_ff <= aw_hold_ff && w_hold_ff && !bvalid_ff;
			if (bready)
				bvalid_ff <= 1'b0;
		end
	end
	// ****************************************
	// Table pointer and holding buffer
	// ****************************************
	logic [7:0] page_ff;
	logic [15:0] ea_ff;
	logic [23:0] tgt_ff;
	logic [6:0] fill_ff;
	logic [23:0] hbuf [0:ROW_WORDS-1];
	logic [5:0] slot;
	logic wr_low, wr_high, start_ok;
	assign slot = ea_ff[ROW_LSB-1:1];
	assign wr_low = wr_fire && waddr_ff == A_TLOW;
	assign wr_high = wr_fire && waddr_ff == A_THIGH;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_ff <= 8'h00;
			ea_ff <= 16'h0000;
		end else if (wr_fire && waddr_ff == A_PAGE)
			page_ff <= wdat_ff[7:0];
		else if (wr_fire && waddr_ff == A_EA)
			ea_ff <= wdat_ff[15:0];
	end
	always_ff @(posedge aclk) begin
		flash_raddr_ff <= {page_ff, ea_ff};
		buf_data_ff <= hbuf[buf_idx];
		if (wr_low && wstb_ff[0])
			hbuf[slot][7:0] <= wdat_ff[7:0];
		if (wr_low && wstb_ff[1])
			hbuf[slot][15:8] <= wdat_ff[15:8];
		if (wr_high && wstb_ff[0])
			hbuf[slot][23:16] <= wdat_ff[7:0];
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !warm_rst_n) begin
			tgt_ff <= 24'h00_0000;
			fill_ff <= 7'h00;
		end else begin
			if (wr_low)
				tgt_ff <= {page_ff, ea_ff};
			if (start_ok)
				fill_ff <= 7'h00;
			else if (wr_high && fill_ff != FILL_FULL)
				fill_ff <= fill_ff + 7'h01;
		end
	end
	// ****************************************
	// Unlock keys, control register and sequencing
	// ****************************************
	fsp_key_e key_ff;
	logic [15:0] ctrl_ff;
	logic start_req, gate_new, done, abort, rc_tick_ff, rd_map;
	fsp_op_e dec;
	assign start_req = wr_fire && waddr_ff == A_CTRL && wstb_ff[1] &&
		wdat_ff[B_START];
	assign gate_new = wstb_ff[1] ? wdat_ff[B_GATE] : ctrl_ff[B_GATE];
	assign start_ok = start_req && key_ff == KEY_ARMED && gate_new &&
		!cpu_stall_ff;
	assign abort = !warm_rst_n && cpu_stall_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || !warm_rst_n) begin
			key_ff <= KEY_IDLE;
		end else if (wr_fire) begin
			// Any other write between the keys breaks the sequence.
			key_ff <= KEY_IDLE;
			if (waddr_ff == A_KEY && wdat_ff[7:0] == KEY1)
				key_ff <= KEY_HALF;
			if (waddr_ff == A_KEY && wdat_ff[7:0] == KEY2 &&
				key_ff == KEY_HALF)
				key_ff <= KEY_ARMED;
		end
	end
	// Only the power-on reset clears the control bits, save the start bit, which a warm reset also clears during an operation.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= CTRL_RST;
		end else begin
			if (wr_fire && waddr_ff == A_CTRL && !cpu_stall_ff) begin
				if (wstb_ff[0]) begin
					ctrl_ff[B_ERASE] <= wdat_ff[B_ERASE];
					ctrl_ff[3:0] <= wdat_ff[3:0];
				end
				if (wstb_ff[1]) begin
					ctrl_ff[B_GATE] <= wdat_ff[B_GATE];
					ctrl_ff[B_ERR] <= wdat_ff[B_ERR];
				end
			end
			if (start_ok)
				ctrl_ff[B_START] <= 1'b1;
			else if (done || abort)
				ctrl_ff[B_START] <= 1'b0;
			// A new error wins over a clear in the same cycle.
			if ((start_req && !start_ok) || abort)
				ctrl_ff[B_ERR] <= 1'b1;
		end
	end
	always_comb begin
		case ({ctrl_ff[B_ERASE], ctrl_ff[3:0]})
			{1'b1, OP_BULK}: dec = FSP_BULK;
			{1'b1, OP_PAGE}: dec = FSP_PAGE;
			{1'b1, OP_GSEG}: dec = FSP_GSEG;
			{1'b1, OP_SSEG}: dec = FSP_SSEG;
			{1'b0, OP_ROW}: dec = FSP_ROW;
			{1'b0, OP_WORD}: dec = FSP_WORD;
			default: dec = FSP_NONE;
		endcase
	end
	logic [16:0] acc_ff;
	logic [19:0] rem_ff;
	// The oscillator is modelled at nominal rate; tuning is not tracked.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_ff <= 17'h0_0000;
			rc_tick_ff <= 1'b0;
		end else if (acc_ff + ACC_STEP >= ACC_WRAP) begin
			acc_ff <= acc_ff + ACC_STEP - ACC_WRAP;
			rc_tick_ff <= 1'b1;
		end else begin
			acc_ff <= acc_ff + ACC_STEP;
			rc_tick_ff <= 1'b0;
		end
	end
	assign done = cpu_stall_ff && !abort &&
		(cmd_ff.kind == FSP_NONE || (rem_ff == 20'h0_0000 && rc_tick_ff));
	always_ff @(posedge aclk) begin
		if (!aresetn || !warm_rst_n) begin
			cpu_stall_ff <= 1'b0;
			cmd_go_ff <= 1'b0;
			cmd_ff <= '{kind: FSP_NONE, addr: 24'h00_0000};
			rem_ff <= 20'h0_0000;
		end else if (start_ok) begin
			cpu_stall_ff <= 1'b1;
			cmd_go_ff <= dec != FSP_NONE;
			cmd_ff.kind <= dec;
			cmd_ff.addr <= 24'h00_0000;
			rem_ff <= 20'(BULK_RC - 1);
			case (dec)
				FSP_PAGE: begin
					cmd_ff.addr <= {tgt_ff[23:PAGE_LSB], 10'h000};
					rem_ff <= 20'(PAGE_RC - 1);
				end
				FSP_ROW: begin
					cmd_ff.addr <= {tgt_ff[23:ROW_LSB], 7'h00};
					rem_ff <= 20'(ROW_RC - 1);
				end
				FSP_WORD: begin
					cmd_ff.addr <= {tgt_ff[23:1], 1'b0};
					rem_ff <= 20'(WORD_RC - 1);
				end
				default: cmd_ff.addr <= 24'h00_0000;
			endcase
		end else begin
			cmd_go_ff <= 1'b0;
			if (done)
				cpu_stall_ff <= 1'b0;
			else if (cpu_stall_ff && rc_tick_ff)
				rem_ff <= rem_ff - 20'h0_0001;
		end
	end
	// ****************************************
	// Bus read path
	// ****************************************
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_map = 1'b1;
		if (araddr == A_CTRL)
			rd_mux = {16'h0000, ctrl_ff & CTRL_MASK};
		else if (araddr == A_KEY)
			rd_mux = 32'h0000_0000;
		else if (araddr == A_PAGE)
			rd_mux = {24'h00_0000, page_ff};
		else if (araddr == A_EA)
			rd_mux = {16'h0000, ea_ff};
		else if (araddr == A_TLOW)
			rd_mux = {16'h0000, flash_rdata[15:0]};
		else if (araddr == A_THIGH)
			rd_mux = {24'h00_0000, flash_rdata[23:16]};
		else if (araddr == A_STAT)
			rd_mux = {23'h00_0000, cpu_stall_ff, 1'b0, fill_ff};
		else
			rd_map = 1'b0;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OK;
			rd_addr_ff <= 8'h00;
		end else if (arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= rd_map ? RESP_OK : RESP_ERR;
			rd_addr_ff <= araddr;
		end else if (!rvalid_ff || rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_start_after_keys: assert property (
		$rose(ctrl_ff[B_START]) |-> $past(key_ff) == KEY_ARMED &&
			$past(gate_new)) else $error("start without keys");
	a_start_self_clear: assert property (
		$fell(ctrl_ff[B_START]) |-> $past(cpu_stall_ff) && !cpu_stall_ff)
		else $error("start bit cleared while idle");
	a_bad_start_err: assert property (
		start_req && !start_ok |=> ctrl_ff[B_ERR])
		else $error("error flag not set");
	a_stall_with_start: assert property (
		ctrl_ff[B_START] |-> cpu_stall_ff)
		else $error("no stall during operation");
	a_row_aligned: assert property (
		cmd_go_ff && cmd_ff.kind == FSP_ROW |-> cmd_ff.addr[6:0] == 7'h00)
		else $error("row not aligned");
	a_page_aligned: assert property (
		cmd_go_ff && cmd_ff.kind == FSP_PAGE |-> cmd_ff.addr[9:0] == 10'h000)
		else $error("page not aligned");
	a_mismatch_nop: assert property (
		start_ok && !ctrl_ff[B_ERASE] && ctrl_ff[3:0] == OP_PAGE
		|=> !cmd_go_ff ##1 !cpu_stall_ff) else $error("mismatch not nop");
	a_gate_needed: assert property (
		$rose(cpu_stall_ff) |-> ctrl_ff[B_GATE])
		else $error("operation without gate");
	a_ctrl_zero_bits: assert property (
		rvalid_ff && rd_addr_ff == A_CTRL |-> (rdata_ff[15:0] & ~CTRL_MASK)
			== 16'h0000 && rdata_ff[31:16] == 16'h0000)
		else $error("unimplemented bits set");
	a_high_phantom: assert property (
		rvalid_ff && rd_addr_ff == A_THIGH |-> rdata_ff[31:8] == 24'h00_0000)
		else $error("phantom byte not zero");
	a_tblwt_two: assert property (
		$rose(bvalid_ff) && wr_tbl |-> $past(aw_hold_ff && w_hold_ff, 2))
		else $error("table write not two cycles");
	c_row_program: cover property (cmd_go_ff && cmd_ff.kind == FSP_ROW);
	c_page_erase: cover property (cmd_go_ff && cmd_ff.kind == FSP_PAGE);
	c_seq_error: cover property ($rose(ctrl_ff[B_ERR]));
	c_buffer_full: cover property (fill_ff == FILL_FULL);
endmodule

// File: include/fsp_pkg.sv
// ****************************************
// Constants and types of the flash sequencer
// ****************************************
package fsp_pkg;
	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_KEY = 8'h04;
	localparam logic [7:0] A_PAGE = 8'h08;
	localparam logic [7:0] A_EA = 8'h0c;
	localparam logic [7:0] A_TLOW = 8'h10;
	localparam logic [7:0] A_THIGH = 8'h14;
	localparam logic [7:0] A_STAT = 8'h18;
	// Control register layout.
	localparam int B_START = 15;
	localparam int B_GATE = 14;
	localparam int B_ERR = 13;
	localparam int B_ERASE = 6;
	localparam logic [15:0] CTRL_MASK = 16'he04f;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	// Operation codes and unlock keys.
	localparam logic [3:0] OP_BULK = 4'hf;
	localparam logic [3:0] OP_GSEG = 4'hd;
	localparam logic [3:0] OP_SSEG = 4'hc;
	localparam logic [3:0] OP_WORD = 4'h3;
	localparam logic [3:0] OP_PAGE = 4'h2;
	localparam logic [3:0] OP_ROW = 4'h1;
	localparam logic [7:0] KEY1 = 8'h55;
	localparam logic [7:0] KEY2 = 8'haa;
	// Geometry in program address units, two per instruction word.
	localparam int ROW_WORDS = 64;
	localparam int PAGE_ROWS = 8;
	localparam int PAGE_WORDS = ROW_WORDS * PAGE_ROWS;
	localparam int ROW_LSB = 7;
	localparam int PAGE_LSB = 10;
	localparam logic [6:0] FILL_FULL = 7'h40;
	// Timing: oscillator rate and system clock rate in kHz.
	localparam int FRC_KHZ = 7370;
	localparam int CLK_KHZ = 100000;
	localparam logic [16:0] ACC_STEP = 17'(FRC_KHZ);
	localparam logic [16:0] ACC_WRAP = 17'(CLK_KHZ);
	localparam int ROW_RC_CYCLES = 11064;
	localparam int TBLWT_CYCLES = 2;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [2:0] {
		FSP_NONE, FSP_BULK, FSP_PAGE, FSP_ROW, FSP_WORD, FSP_GSEG, FSP_SSEG
	} fsp_op_e;
	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} fsp_key_e;
	typedef struct packed {
		fsp_op_e kind;
		logic [23:0] addr;
	} fsp_cmd_s;
endpackage
